// *** src/pcw_consts.vh ***
// constants for the power, clock and wake manager
`ifndef PCW_CONSTS_VH
`define PCW_CONSTS_VH
// ---------------------------------------------------------------
// clock
// ---------------------------------------------------------------
`define CLK_HZ            20000000
`define IDLE_TIME_S       5
// CLK_HZ times IDLE_TIME_S, sized to the timer width
`define IDLE_CYCLES       27'h5F5E100
`define IDLE_CNT_W        27
// ---------------------------------------------------------------
// operating clock selection codes
// ---------------------------------------------------------------
`define SEL_48MHZ         2'h0
`define SEL_24MHZ         2'h1
`define SEL_12MHZ         2'h2
`define DIV_48MHZ         4'h1
`define DIV_24MHZ         4'h2
`define DIV_12MHZ         4'h4
`define IDLE_CLK_HZ       30000
// ---------------------------------------------------------------
// parameter word layout (fuse and eeprom)
// ---------------------------------------------------------------
`define PARAM_W           32
`define P_IDLE_EN         0
`define P_RI_WAKE_EN      1
`define P_CLK_SEL_LSB     2
`define P_PIN_FN_LSB      4
`define PIN_COUNT         14
`define PIN_FN_W          14
`define PIN_FN_WAKE       0
`define PIN_FN_RI         1
// pin function bit set: 1 selects ri at the ri pin, 0 selects wake at the wake pin
`define PIN_WAKE_IDX      8
`define PIN_RI_IDX        11
`define PARAM_RESET       32'h00000000
// ---------------------------------------------------------------
// start-up eeprom probe
// ---------------------------------------------------------------
`define EE_TIMEOUT        16'h0FA0
`endif

// *** src/pin_sync.v ***
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

// *** src/idle_timer.v ***
// inactivity timer that flags a long quiet period
`timescale 1ns/1ps
`include "pcw_consts.vh"
module idle_timer #(
  parameter [`IDLE_CNT_W-1:0] LIMIT = `IDLE_CYCLES
) (
  input  wire clk,
  input  wire rst_n,
  input  wire enable,
  input  wire activity,
  output reg  expired
);
  reg [`IDLE_CNT_W-1:0] cnt_q;

  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_q   <= {`IDLE_CNT_W{1'b0}};
      expired <= 1'b0;
    end else if (!enable || activity) begin
      cnt_q   <= {`IDLE_CNT_W{1'b0}};
      expired <= 1'b0;
    end else if (cnt_q >= LIMIT - 1'b1) begin
      expired <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule

// *** src/power_clock_wake_manager.v ***
// power, clock selection, idle, suspend and remote wake manager
//
// Overview of operation
// - operating clock runs at 48, 24 or 12 MHz as selected
// - idle mode allowed only when stored parameter enables it
// - idle: drop to 30 kHz after 5 s with no data movement
// - any uart receive activity ends idle, full chip back to normal
// - usb suspend gates clock to most digital logic
// - while suspended with host permission, wake pin assertion drives usb resume signalling, only if pin is wake
// - ring indicator wakes too, only if pin is ri and enabled
// - at power-up probe eeprom, load parameters, then operate by them
// - eeprom parameters take precedence over fuse parameters
// - each of 14 pin functions set from parameters or usb commands
// - clocks derive from 48 MHz oscillator, chosen by usb command
// - during start-up two pins act as i2c lines to the eeprom
`timescale 1ns/1ps
`include "pcw_consts.vh"
module power_clock_wake_manager #(
  parameter [`IDLE_CNT_W-1:0] IDLE_LIMIT = `IDLE_CYCLES
) (
  input  wire                  clk,
  input  wire                  rst_n,
  input  wire [`PARAM_W-1:0]   fuse_params,
  input  wire                  ee_present,
  input  wire                  ee_done,
  input  wire [`PARAM_W-1:0]   ee_params,
  output reg                   ee_probe,
  output reg                   ee_i2c_en,
  output reg                   config_done,
  input  wire                  cmd_clk_valid,
  input  wire [1:0]            cmd_clk_sel,
  input  wire                  cmd_pin_valid,
  input  wire [`PIN_FN_W-1:0]  cmd_pin_fn,
  input  wire                  data_xfer,
  input  wire                  uart_rx,
  input  wire                  usb_suspend,
  input  wire                  remote_wake_allowed,
  input  wire                  host_resume_request_pin,
  input  wire                  ring_indicator_input,
  output reg  [`PIN_FN_W-1:0]  pin_function,
  output reg  [1:0]            clk_sel,
  output reg  [3:0]            clk_div,
  output reg                   idle_clk_on,
  output reg                   core_clk_gate,
  output reg                   resume_drive,
  output reg                   idle_active
);
  // ---------------------------------------------------------------
  // divide ratio from a selection code
  // ---------------------------------------------------------------
  function [3:0] sel_to_div;
    input [1:0] s;
    begin
      case (s)
        `SEL_24MHZ: sel_to_div = `DIV_24MHZ;
        `SEL_12MHZ: sel_to_div = `DIV_12MHZ;
        default:    sel_to_div = `DIV_48MHZ;
      endcase
    end
  endfunction

  // an unused code falls back to full speed rather than stall
  function [1:0] legal_sel;
    input [1:0] s;
    begin
      legal_sel = (s == 2'h3) ? `SEL_48MHZ : s;
    end
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  wire [3:0] pins_s;
  pin_sync #(
    .W (4)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({uart_rx, host_resume_request_pin,
             ring_indicator_input, usb_suspend}),
    .q     (pins_s)
  );
  wire rx_s      = pins_s[3];
  wire wake_s    = pins_s[2];
  wire ri_s      = pins_s[1];
  wire suspend_s = pins_s[0];

  reg rx_prev_q;
  reg wake_prev_q;
  reg ri_prev_q;

  // ---------------------------------------------------------------
  // start-up configuration
  // ---------------------------------------------------------------
  localparam ST_PROBE = 2'h0;
  localparam ST_LOAD  = 2'h1;
  localparam ST_RUN   = 2'h2;

  reg [1:0]          st_q;
  reg [15:0]         probe_cnt_q;
  reg [`PARAM_W-1:0] params_q;

  wire idle_en    = params_q[`P_IDLE_EN];
  wire ri_wake_en = params_q[`P_RI_WAKE_EN];

  always @(posedge clk) begin
    if (!rst_n) begin
      st_q        <= ST_PROBE;
      probe_cnt_q <= 16'h0000;
      params_q    <= `PARAM_RESET;
      ee_probe    <= 1'b0;
      ee_i2c_en   <= 1'b0;
      config_done <= 1'b0;
    end else begin
      case (st_q)
        ST_PROBE: begin
          ee_probe    <= 1'b1;
          ee_i2c_en   <= 1'b1;
          probe_cnt_q <= probe_cnt_q + 16'h0001;
          if (ee_present) begin
            st_q <= ST_LOAD;
          end else if (probe_cnt_q >= `EE_TIMEOUT) begin
            // no eeprom answered: the fuse store alone applies
            params_q    <= fuse_params;
            ee_probe    <= 1'b0;
            ee_i2c_en   <= 1'b0;
            config_done <= 1'b1;
            st_q        <= ST_RUN;
          end
        end
        ST_LOAD: begin
          if (ee_done) begin
            params_q    <= ee_params;
            ee_probe    <= 1'b0;
            ee_i2c_en   <= 1'b0;
            config_done <= 1'b1;
            st_q        <= ST_RUN;
          end
        end
        ST_RUN: begin
          st_q <= ST_RUN;
        end
        default: begin
          st_q <= ST_PROBE;
        end
      endcase
    end
  end

  wire running = (st_q == ST_RUN);
  // parameters land one cycle after the word is stored
  reg  loaded_q;

  // ---------------------------------------------------------------
  // pin functions and clock selection
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      pin_function <= {`PIN_FN_W{1'b0}};
      clk_sel      <= `SEL_48MHZ;
      loaded_q     <= 1'b0;
    end else if (!loaded_q) begin
      loaded_q     <= running;
      pin_function <= params_q[`P_PIN_FN_LSB +: `PIN_FN_W];
      clk_sel <= legal_sel(params_q[`P_CLK_SEL_LSB +: 2]);
    end else begin
      if (cmd_pin_valid) begin
        pin_function <= cmd_pin_fn;
      end
      if (cmd_clk_valid) begin
        clk_sel <= legal_sel(cmd_clk_sel);
      end
    end
  end

  // ---------------------------------------------------------------
  // idle and suspend
  // ---------------------------------------------------------------
  // gated by running: the synchroniser leaves reset low against an idle
  // high line, which would look like an edge
  wire rx_edge = (rx_s ^ rx_prev_q) & running;
  wire idle_expired;

  idle_timer #(
    .LIMIT (IDLE_LIMIT)
  ) u_idle (
    .clk      (clk),
    .rst_n    (rst_n),
    .enable   (running & idle_en & ~suspend_s),
    .activity (data_xfer | rx_edge),
    .expired  (idle_expired)
  );

  wire wake_rise = wake_s & ~wake_prev_q;
  wire ri_rise   = ri_s & ~ri_prev_q;
  wire ri_wake   = ri_rise & ri_wake_en
                 & pin_function[`PIN_RI_IDX];
  wire pin_wake  = wake_rise
                 & ~pin_function[`PIN_WAKE_IDX];

  always @(posedge clk) begin
    if (!rst_n) begin
      rx_prev_q     <= 1'b0;
      wake_prev_q   <= 1'b0;
      ri_prev_q     <= 1'b0;
      idle_active   <= 1'b0;
      idle_clk_on   <= 1'b0;
      core_clk_gate <= 1'b0;
      resume_drive  <= 1'b0;
      clk_div       <= `DIV_48MHZ;
    end else begin
      rx_prev_q   <= rx_s;
      wake_prev_q <= wake_s;
      ri_prev_q   <= ri_s;
      // rx activity wins over a timer expiry in the same cycle
      if (rx_edge || !idle_en) begin
        idle_active <= 1'b0;
      end else if (idle_expired) begin
        idle_active <= 1'b1;
      end
      idle_clk_on   <= idle_active & ~suspend_s;
      core_clk_gate <= suspend_s;
      clk_div       <= sel_to_div(clk_sel);
      // resume drive only while suspended; host permission required
      resume_drive  <= suspend_s & remote_wake_allowed
                     & (pin_wake | ri_wake
                        | (resume_drive & wake_s));
    end
  end
endmodule

// *** tb/pcw_sva.sv ***
// port checker for the power, clock and wake manager
`timescale 1ns/1ps
module pcw_sva (
  input wire       clk,
  input wire       rst_n,
  input wire       data_xfer,
  input wire       uart_rx,
  input wire       usb_suspend,
  input wire       remote_wake_allowed,
  input wire       ee_probe,
  input wire       config_done,
  input wire [1:0] clk_sel,
  input wire [3:0] clk_div,
  input wire       idle_clk_on,
  input wire       core_clk_gate,
  input wire       resume_drive,
  input wire       idle_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // --
  // suspend steps
  // --
  sequence s_gated;
    ##[2:4] core_clk_gate;
  endsequence
  sequence s_ungated;
    ##[2:4] !core_clk_gate;
  endsequence
  a_sel_legal: assert property (clk_sel != 2'h3)
    else $error("clock select out of range");
  a_div_map: assert property (1 |=> clk_div ==
    ($past(clk_sel) == 2'h1 ? 4'h2 : $past(clk_sel) == 2'h2 ? 4'h4 : 4'h1))
    else $error("divider does not follow select");
  a_idle_cfg: assert property (idle_active |-> config_done)
    else $error("idle before configuration");
  a_idle_clk: assert property ($rose(idle_active) |=> idle_clk_on)
    else $error("slow clock not selected in idle");
  a_rx_exit: assert property
    ($changed(uart_rx) && idle_active |-> ##[1:4] !idle_active)
    else $error("receive activity did not end idle");
  a_xfer_holds: assert property
    (data_xfer |=> !$rose(idle_active) ##1 !$rose(idle_active))
    else $error("idle entered right after transfer");
  a_gate_on: assert property
    ($rose(usb_suspend) && config_done |-> s_gated)
    else $error("suspend did not gate clocks");
  a_gate_off: assert property
    ($fell(usb_suspend) && config_done |-> s_ungated)
    else $error("resume did not restore clocks");
  a_resume_why: assert property ($rose(resume_drive) |->
    core_clk_gate && $past(remote_wake_allowed))
    else $error("resume driven without cause");
  a_probe_done: assert property
    ($rose(config_done) |-> $past(ee_probe))
    else $error("configured without probing");
  a_done_holds: assert property (config_done |=> config_done)
    else $error("configuration flag dropped");
endmodule
bind power_clock_wake_manager pcw_sva pcw_sva_inst (.*);

// *** tb/usb_host_model.sv ***
// usb host side: suspends the device, ends suspend on resume
`timescale 1ns/1ps
module usb_host_model (
  input  wire clk,
  input  wire suspend_req,
  input  wire wake_ok,
  input  wire resume_drive,
  output reg  usb_suspend = 1'b0,
  output reg  remote_wake_allowed = 1'b0
);
  always @(posedge clk) begin
    remote_wake_allowed <= wake_ok;
    // host answers resume signalling by leaving suspend
    if (resume_drive)
      usb_suspend <= 1'b0;
    else if (suspend_req)
      usb_suspend <= 1'b1;
  end
endmodule

// *** tb/power_clock_wake_manager_tb.sv ***
// testbench for the power, clock and wake manager
`timescale 1ns/1ps
module power_clock_wake_manager_tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [31:0] fuse_params = 32'h00001234;
  reg  [31:0] ee_params = 32'h0000800B;
  reg         ee_present = 1'b0, ee_done = 1'b0, data_xfer = 1'b0;
  reg         cmd_clk_valid = 1'b0, cmd_pin_valid = 1'b0, uart_rx = 1'b1;
  reg  [1:0]  cmd_clk_sel = 2'h0;
  reg  [13:0] cmd_pin_fn = 14'h0000;
  reg         host_resume_request_pin = 1'b0, ring_indicator_input = 1'b0;
  reg         suspend_req = 1'b0, wake_ok = 1'b0;
  wire        ee_probe, ee_i2c_en, config_done, idle_clk_on, idle_active;
  wire        core_clk_gate, resume_drive, usb_suspend, remote_wake_allowed;
  wire [13:0] pin_function;
  wire [1:0]  clk_sel;
  wire [3:0]  clk_div;
  integer     n_mismatch = 0, n_tests = 0, cyc = 0;
  // short idle limit keeps the run small
  power_clock_wake_manager #(.IDLE_LIMIT(27'h0000032))
    power_clock_wake_manager_inst (.*);
  usb_host_model usb_host_model_inst (.*);
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test;
    end
  end
  // --
  // helpers
  // --
  task chk(input [31:0] got, input [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task w(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task boot(input pres);
    @(posedge clk);
    rst_n <= 1'b0;
    ee_present <= pres;
    w(10);
    @(posedge clk);
    rst_n <= 1'b1;
    w(3);
    chk(ee_i2c_en, 1);
    chk(ee_probe, 1);
    if (pres) begin
      @(posedge clk);
      ee_done <= 1'b1;
      @(posedge clk);
      ee_done <= 1'b0;
    end
    repeat (5000) if (config_done !== 1'b1) w(1);
    chk(config_done, 1);
    chk(ee_probe, 0);
    chk(ee_i2c_en, 0);
    // parameters reach pin_function and clk_sel one cycle after config_done, clk_div a cycle later
    w(2);
  endtask
  // --
  // scenarios
  // --
  task t_fuse;
    boot(1'b0);
    chk(clk_sel, 2'h1);
    chk(pin_function, 14'h0123);
    w(120);
    chk(idle_active, 0);
    chk(clk_div, 4'h2);
  endtask
  task t_eeprom;
    boot(1'b1);
    chk(clk_sel, 2'h2);
    chk(pin_function, 14'h0800);
  endtask
  task t_idle;
    repeat (6) begin
      @(posedge clk);
      data_xfer <= 1'b1;
      @(posedge clk);
      data_xfer <= 1'b0;
      w(30);
    end
    chk(idle_active, 0);
    w(60);
    chk(idle_clk_on, 1);
    @(posedge clk);
    uart_rx <= 1'b0;
    w(8);
    chk(idle_clk_on, 0);
    @(posedge clk);
    uart_rx <= 1'b1;
  endtask
  task t_wake(input ri);
    @(posedge clk);
    suspend_req <= 1'b1;
    wake_ok <= 1'b0;
    @(posedge clk);
    suspend_req <= 1'b0;
    w(6);
    chk(core_clk_gate, 1);
    @(posedge clk);
    host_resume_request_pin <= !ri;
    ring_indicator_input <= ri;
    w(8);
    chk(resume_drive, 0);
    @(posedge clk);
    host_resume_request_pin <= 1'b0;
    ring_indicator_input <= 1'b0;
    wake_ok <= 1'b1;
    w(4);
    @(posedge clk);
    host_resume_request_pin <= !ri;
    ring_indicator_input <= ri;
    repeat (8) if (resume_drive !== 1'b1) w(1);
    chk(resume_drive, 1);
    w(12);
    chk(core_clk_gate, 0);
    chk(clk_sel, 2'h2);
    @(posedge clk);
    host_resume_request_pin <= 1'b0;
    ring_indicator_input <= 1'b0;
  endtask
  task t_cmd;
    integer i;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk);
      cmd_clk_valid <= 1'b1;
      cmd_clk_sel <= i[1:0];
      cmd_pin_valid <= 1'b1;
      cmd_pin_fn <= 14'h3FFF >> i;
      @(posedge clk);
      cmd_clk_valid <= 1'b0;
      cmd_pin_valid <= 1'b0;
      w(2);
      chk(clk_div, 4'h1 << (i % 3));
      chk(clk_sel, i % 3);
      chk(pin_function, 14'h3FFF >> i);
    end
  endtask
  task end_of_test;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    t_fuse;
    t_eeprom;
    t_idle;
    t_wake(1'b0);
    t_wake(1'b1);
    t_cmd;
    end_of_test;
  end
endmodule
